// File: rtl/measurement_pkg.sv
// constants for the motor measurement readout bank
package measurement_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FIELD_W = 16;
    // register offsets as printed
    localparam logic [11:0] PHASE_ONE_CURRENT_OFS = 12'h043e;
    localparam logic [11:0] PHASE_TWO_CURRENT_OFS = 12'h0440;
    localparam logic [11:0] PHASE_THREE_CURRENT_OFS = 12'h0442;
    localparam logic [11:0] SENSE_GAIN_READBACK_OFS = 12'h0466;
    localparam logic [11:0] VOLTAGE_RANGE_READBACK_OFS = 12'h0476;
    localparam logic [11:0] SUPPLY_BUS_VOLTAGE_OFS = 12'h0478;
    // reset values
    localparam logic [31:0] MEAS_RESET = 32'h0000_0000;
    localparam logic [15:0] FIELD_RESET = 16'h0000;
    localparam logic [15:0] RESERVED_ZERO = 16'h0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // scaling: amperes = value / 2**27 * 1.25, volts = value * 60 / 2**27
    localparam int FRAC_BITS = 27;
    // sense gain codes (V/A): 1.2, 0.6, 0.3, 0.15
    localparam logic [15:0] GAIN_1P2 = 16'h0000;
    localparam logic [15:0] GAIN_0P6 = 16'h0001;
    localparam logic [15:0] GAIN_0P3 = 16'h0002;
    localparam logic [15:0] GAIN_0P15 = 16'h0003;
    // voltage range codes: 60 V, 30 V, 15 V full scale
    localparam logic [15:0] RANGE_60V = 16'h0000;
    localparam logic [15:0] RANGE_30V = 16'h0001;
    localparam logic [15:0] RANGE_15V = 16'h0002;
endpackage

// File: rtl/motor_measurement_readout.sv
// read-only measurement register bank of the motor driver
// What this block does
// - phase one current, 32-bit read-only, Q27*1.25A
// - phase two current, same scaling, read-only
// - phase three current, read-only, resets zero
// - sense gain codes 0..3 in low half
// - voltage range codes 0..2 in low half
// - supply bus voltage, value*60/2^27 volts
// - sense gain register resets zero, upper zero
// - voltage range register resets zero, upper zero
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module motor_measurement_readout
    import measurement_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    // values from the control algorithm, sampled every clock while update is high
    input wire logic update_in,
    input wire logic [31:0] phase_one_current_in,
    input wire logic [31:0] phase_two_current_in,
    input wire logic [31:0] phase_three_current_in,
    input wire logic [1:0] sense_gain_in,
    input wire logic [1:0] voltage_range_in,
    input wire logic [31:0] supply_bus_voltage_in,
    // register port
    input wire logic [11:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [31:0] rdata_out,
    output logic sense_gain_out_of_range_out
);
    logic [31:0] phase_one_current;
    logic [31:0] phase_two_current;
    logic [31:0] phase_three_current;
    logic [15:0] sense_gain_readback;
    logic [15:0] voltage_range_readback;
    logic [31:0] supply_bus_voltage;
    logic [31:0] rdata;
    logic range_bad;

    logic [31:0] next_phase_one_current;
    logic [31:0] next_phase_two_current;
    logic [31:0] next_phase_three_current;
    logic [15:0] next_sense_gain_readback;
    logic [15:0] next_voltage_range_readback;
    logic [31:0] next_supply_bus_voltage;
    logic [31:0] next_rdata;
    logic next_range_bad;

    // measurement capture; the bus write path never reaches these
    always_comb begin
        next_phase_one_current = phase_one_current;
        next_phase_two_current = phase_two_current;
        next_phase_three_current = phase_three_current;
        next_sense_gain_readback = sense_gain_readback;
        next_voltage_range_readback = voltage_range_readback;
        next_supply_bus_voltage = supply_bus_voltage;
        next_range_bad = range_bad;
        if (update_in) begin
            next_phase_one_current = phase_one_current_in;
            next_phase_two_current = phase_two_current_in;
            next_phase_three_current = phase_three_current_in;
            next_sense_gain_readback = {14'h0000, sense_gain_in};
            // code 3 is undefined for the range; hold the last legal code
            if ({14'h0000, voltage_range_in} <= RANGE_15V) begin
                next_voltage_range_readback = {14'h0000, voltage_range_in};
                next_range_bad = 1'b0;
            end else begin
                next_range_bad = 1'b1;
            end
            next_supply_bus_voltage = supply_bus_voltage_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            phase_one_current <= MEAS_RESET;
            phase_two_current <= MEAS_RESET;
            phase_three_current <= MEAS_RESET;
            sense_gain_readback <= FIELD_RESET;
            voltage_range_readback <= FIELD_RESET;
            supply_bus_voltage <= MEAS_RESET;
            range_bad <= 1'b0;
        end else begin
            phase_one_current <= next_phase_one_current;
            phase_two_current <= next_phase_two_current;
            phase_three_current <= next_phase_three_current;
            sense_gain_readback <= next_sense_gain_readback;
            voltage_range_readback <= next_voltage_range_readback;
            supply_bus_voltage <= next_supply_bus_voltage;
            range_bad <= next_range_bad;
        end
    end

    // read mux; data stands only in the cycle after the strobe
    always_comb begin
        next_rdata = UNMAPPED_READ;
        if (read_in) begin
            case (addr_in)
                PHASE_ONE_CURRENT_OFS: next_rdata = phase_one_current;
                PHASE_TWO_CURRENT_OFS: next_rdata = phase_two_current;
                PHASE_THREE_CURRENT_OFS: next_rdata = phase_three_current;
                SENSE_GAIN_READBACK_OFS: next_rdata = {RESERVED_ZERO, sense_gain_readback};
                VOLTAGE_RANGE_READBACK_OFS: next_rdata = {RESERVED_ZERO, voltage_range_readback};
                SUPPLY_BUS_VOLTAGE_OFS: next_rdata = supply_bus_voltage;
                default: next_rdata = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata <= UNMAPPED_READ;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign rdata_out = rdata;
    assign sense_gain_out_of_range_out = range_bad;

    // a write without update leaves phase one, supply voltage, sense gain and voltage range as they were
    a_write_ignored: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (write_in && !update_in) |=> $stable(phase_one_current) && $stable(supply_bus_voltage)
            && $stable(sense_gain_readback) && $stable(voltage_range_readback))
        else $error("write changed a measurement register");

    a_phase_one_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in == PHASE_ONE_CURRENT_OFS) |=> rdata_out == $past(phase_one_current))
        else $error("phase one read mismatch");

    a_phase_two_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in == PHASE_TWO_CURRENT_OFS) |=> rdata_out == $past(phase_two_current))
        else $error("phase two read mismatch");

    sequence s_capture3;
        update_in ##1 1'b1;
    endsequence
    a_phase_three_cap: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_capture3 |-> phase_three_current == $past(phase_three_current_in))
        else $error("phase three not captured");

    a_gain_code: assert property (@(posedge clk_in) disable iff (!rstn_in)
        update_in |=> sense_gain_readback == {14'h0000, $past(sense_gain_in)})
        else $error("sense gain code wrong");

    a_range_code: assert property (@(posedge clk_in) disable iff (!rstn_in)
        voltage_range_readback <= RANGE_15V)
        else $error("voltage range code out of range");

    a_supply_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in == SUPPLY_BUS_VOLTAGE_OFS && !update_in) |=> rdata_out == supply_bus_voltage)
        else $error("supply voltage read mismatch");

    a_gain_upper_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in == SENSE_GAIN_READBACK_OFS) |=> rdata_out[31:2] == 30'h0000_0000)
        else $error("sense gain upper bits nonzero");

    a_range_upper_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in == VOLTAGE_RANGE_READBACK_OFS) |=> rdata_out[31:16] == RESERVED_ZERO)
        else $error("voltage range upper bits nonzero");

    a_rdata_one_cycle: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !read_in |=> rdata_out == UNMAPPED_READ)
        else $error("read data outside its cycle");

    // one idle edge with no capture
    sequence s_idle_step;
        !update_in ##1 1'b1;
    endsequence

    // capture with a legal range code
    sequence s_legal_range;
        (update_in && voltage_range_in != 2'h3) ##1 1'b1;
    endsequence

    // capture with the undefined range code
    sequence s_bad_range;
        (update_in && voltage_range_in == 2'h3) ##1 1'b1;
    endsequence

    a_reset_one_zero: assert property (@(posedge clk_in)
        !rstn_in |=> phase_one_current == MEAS_RESET)
        else $error("phase one not zero after reset");

    a_reset_two_zero: assert property (@(posedge clk_in)
        !rstn_in |=> phase_two_current == MEAS_RESET)
        else $error("phase two not zero after reset");

    a_reset_three_zero: assert property (@(posedge clk_in)
        !rstn_in |=> phase_three_current == MEAS_RESET)
        else $error("phase three not zero after reset");

    a_reset_gain_zero: assert property (@(posedge clk_in)
        !rstn_in |=> sense_gain_readback == FIELD_RESET)
        else $error("sense gain not zero after reset");

    a_reset_range_zero: assert property (@(posedge clk_in)
        !rstn_in |=> voltage_range_readback == FIELD_RESET)
        else $error("voltage range not zero after reset");

    a_reset_supply_zero: assert property (@(posedge clk_in)
        !rstn_in |=> supply_bus_voltage == MEAS_RESET)
        else $error("supply voltage not zero after reset");

    a_reset_rdata_zero: assert property (@(posedge clk_in)
        !rstn_in |=> rdata_out == UNMAPPED_READ)
        else $error("read data not zero after reset");

    a_reset_flag_low: assert property (@(posedge clk_in)
        !rstn_in |=> !sense_gain_out_of_range_out)
        else $error("range flag set after reset");

    a_phase_one_cap: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_capture3 |-> phase_one_current == $past(phase_one_current_in))
        else $error("phase one not captured");

    a_phase_two_cap: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_capture3 |-> phase_two_current == $past(phase_two_current_in))
        else $error("phase two not captured");

    a_supply_cap: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_capture3 |-> supply_bus_voltage == $past(supply_bus_voltage_in))
        else $error("supply voltage not captured");

    a_gain_field_narrow: assert property (@(posedge clk_in) disable iff (!rstn_in)
        sense_gain_readback[15:2] == 14'h0000)
        else $error("sense gain field above code width");

    a_range_field_narrow: assert property (@(posedge clk_in) disable iff (!rstn_in)
        voltage_range_readback[15:2] == 14'h0000)
        else $error("voltage range field above code width");

    a_range_legal_store: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_legal_range |-> !range_bad && voltage_range_readback == {14'h0000, $past(voltage_range_in)})
        else $error("legal range code not stored");

    a_range_bad_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_bad_range |-> range_bad && voltage_range_readback == $past(voltage_range_readback))
        else $error("undefined range code not held off");

    a_hold_phase_one: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_idle_step |-> $stable(phase_one_current))
        else $error("phase one moved without capture");

    a_hold_phase_two: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_idle_step |-> $stable(phase_two_current))
        else $error("phase two moved without capture");

    a_hold_phase_three: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_idle_step |-> $stable(phase_three_current))
        else $error("phase three moved without capture");

    a_hold_gain: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_idle_step |-> $stable(sense_gain_readback))
        else $error("sense gain moved without capture");

    a_hold_range: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_idle_step |-> $stable(voltage_range_readback) && $stable(range_bad))
        else $error("voltage range moved without capture");

    a_hold_supply: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_idle_step |-> $stable(supply_bus_voltage))
        else $error("supply voltage moved without capture");

    a_phase_three_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in == PHASE_THREE_CURRENT_OFS) |=> rdata_out == $past(phase_three_current))
        else $error("phase three read mismatch");

    a_gain_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in == SENSE_GAIN_READBACK_OFS)
            |=> rdata_out == {RESERVED_ZERO, $past(sense_gain_readback)})
        else $error("sense gain read mismatch");

    a_range_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in == VOLTAGE_RANGE_READBACK_OFS)
            |=> rdata_out == {RESERVED_ZERO, $past(voltage_range_readback)})
        else $error("voltage range read mismatch");

    a_supply_past_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in == SUPPLY_BUS_VOLTAGE_OFS) |=> rdata_out == $past(supply_bus_voltage))
        else $error("supply voltage read lost old value");

    a_unmapped_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && addr_in != PHASE_ONE_CURRENT_OFS && addr_in != PHASE_TWO_CURRENT_OFS
            && addr_in != PHASE_THREE_CURRENT_OFS && addr_in != SENSE_GAIN_READBACK_OFS
            && addr_in != VOLTAGE_RANGE_READBACK_OFS && addr_in != SUPPLY_BUS_VOLTAGE_OFS)
            |=> rdata_out == UNMAPPED_READ)
        else $error("unmapped read not zero");

    a_read_during_cap: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (read_in && update_in && addr_in == PHASE_TWO_CURRENT_OFS) |=> rdata_out == $past(phase_two_current))
        else $error("read during capture not old value");

    a_write_keeps_phase: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (write_in && !update_in) |=> $stable(phase_two_current) && $stable(phase_three_current))
        else $error("write changed a phase current");

    a_write_keeps_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (write_in && !update_in) |=> $stable(range_bad))
        else $error("write changed the range flag");
endmodule // motor_measurement_readout
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the motor measurement readout bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import measurement_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic update_in = 1'b0;
    logic write_in = 1'b0;
    logic read_in = 1'b0;
    logic [31:0] cur [3] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] vbus = 32'h0000_0000;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic [31:0] seed = 32'h0001_300a;
    logic [31:0] rdata_out, got;
    logic [1:0] gain = 2'h0;
    logic [1:0] vrange = 2'h0;
    logic [11:0] addr_in = 12'h000;
    logic flag;
    int bad_count = 0;
    int cmp_count = 0;
    // expected contents, same order as the offset table
    logic [31:0] e [6];
    logic [11:0] ofs [6] = '{PHASE_ONE_CURRENT_OFS, PHASE_TWO_CURRENT_OFS, PHASE_THREE_CURRENT_OFS,
        SENSE_GAIN_READBACK_OFS, VOLTAGE_RANGE_READBACK_OFS, SUPPLY_BUS_VOLTAGE_OFS};

    motor_measurement_readout motor_measurement_readout_inst (.clk_in(clk_in), .rstn_in(rstn_in),
        .update_in(update_in), .phase_one_current_in(cur[0]), .phase_two_current_in(cur[1]),
        .phase_three_current_in(cur[2]), .sense_gain_in(gain), .voltage_range_in(vrange),
        .supply_bus_voltage_in(vbus), .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
        .read_in(read_in), .rdata_out(rdata_out), .sense_gain_out_of_range_out(flag));

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // 16-bit code field with zero upper half
    function automatic logic [31:0] field(input logic [1:0] c);
        return {30'h0000_0000, c};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_in);
        read_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        read_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic check_all();
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], got);
            chk("register", got, e[i]);
        end
    endtask
    task automatic upd(input logic [1:0] g, input logic [1:0] v);
        @(posedge clk_in);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            cur[k] <= seed;
            e[k] = seed;
        end
        seed = lfsr(seed);
        vbus <= seed;
        e[5] = seed;
        gain <= g;
        vrange <= v;
        update_in <= 1'b1;
        e[3] = field(g);
        if (v != 2'h3) e[4] = field(v);
        @(posedge clk_in);
        update_in <= 1'b0;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        bad_count++;
        close_out();
    end
    initial begin
        for (int i = 0; i < 6; i++) e[i] = 32'h0000_0000;
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        check_all();
        rd(12'h0444, got);
        chk("unmapped", got, UNMAPPED_READ);
        for (int i = 0; i < 12; i++) begin
            upd(2'(i % 4), 2'(i % 3));
            check_all();
        end
        upd(2'h1, 2'h3);
        #1 chk("flag set", {31'h0000_0000, flag}, 32'h0000_0001);
        check_all();
        upd(2'h2, 2'h2);
        #1 chk("flag clear", {31'h0000_0000, flag}, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_in);
            write_in <= 1'b1;
            addr_in <= ofs[i];
            wdata_in <= ~e[i];
            @(posedge clk_in);
            write_in <= 1'b0;
        end
        check_all();
        close_out();
    end
endmodule // tb_top
`default_nettype wire
